/* File: hdl/csr_pkg.sv */
/*
 Constants shared by both ends of the crate control-register link:
 register map, field positions, frame lengths and timing counts.
 Assumes a single 20 MHz controller clock on both ends.
*/
package csr_pkg;
	// Controller clock rate.
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned CLK_MHZ = 20;
	// Access widths carried on the link.
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 8;
	// Address frame is 16 bits: read flag on top, twelve address bits at the bottom.
	localparam int unsigned ADDR_FRAME_BITS = 16;
	localparam int unsigned DATA_FRAME_BITS = 8;
	localparam int unsigned RW_BIT = 15;
	localparam int unsigned BITCNT_W = 5;
	// Register offsets.
	localparam logic [11:0] REG_CTRL_ID = 12'h000;
	localparam logic [11:0] REG_TEST = 12'h001;
	localparam logic [11:0] REG_RATE_LO = 12'h002;
	localparam logic [11:0] REG_RATE_HI = 12'h003;
	localparam logic [11:0] REG_OCC_LO = 12'h004;
	localparam logic [11:0] REG_OCC_HI = 12'h005;
	// Field positions.
	localparam int unsigned SOFT_RST_BIT = 0;
	localparam int unsigned LOOPBACK_BIT = 0;
	localparam int unsigned SLOW_BIT = 1;
	localparam int unsigned CARD_BIT = 7;
	// Reset values.
	localparam logic SOFT_RST_RESET = 1'b0;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [15:0] VEC_ZERO = 16'h0000;
	// Identification string: 512 bytes, a short text then zero fill.
	localparam int unsigned ID_LEN = 512;
	localparam int unsigned ID_PTR_W = 9;
	localparam int unsigned ID_TEXT_LEN = 16;
	// Arbitrary text, names no maker or part.
	localparam logic [127:0] ID_TEXT = "CRATE-CTRL-FW-01";
	// Serial clock half period on the host end, in controller cycles.
	localparam int unsigned SCK_HALF_CYC = 4;
	localparam int unsigned DIV_W = 3;
	// Interrupt pulse width and processor reset hold, in ns and cycles.
	localparam int unsigned IRQ_HOLD_NS = 1000;
	localparam int unsigned IRQ_HOLD_CYC = (IRQ_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned RST_HOLD_NS = 1000;
	localparam int unsigned RST_HOLD_CYC = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
	// Watchdog timeout in seconds and default cycle count.
	localparam int unsigned WDOG_TIMEOUT_S = 9;
	localparam int unsigned WDOG_CYC_DEF = WDOG_TIMEOUT_S * CLK_HZ;
	// Host end sequencer states.
	typedef enum logic [1:0]
	{
		CSR_H_IDLE = 2'b00,
		CSR_H_SHIFT = 2'b01,
		CSR_H_GAP = 2'b10,
		CSR_H_DONE = 2'b11
	} csr_host_state_t;
endpackage

/* File: hdl/csr_link_if.sv */
/*
 Link between the processor (host end) and the control-register logic
 (device end): serial register port plus side-band lines.
 Assumes both ends share the controller clock; all lines are plain levels.
*/
`timescale 1ns/1ns
interface csr_link_if;
	logic sclk; // Serial clock, driven by the host.
	logic mosi; // Host to device data.
	logic miso; // Device to host data.
	logic sel_n; // Register port select, low during a frame.
	logic tx_space_ready; // Device can take up to 128 words on the serial transmit port.
	logic config_change_irq; // Installed module set changed.
	logic nmi; // Rises when supply loss is imminent.
	logic watchdog_kick_strobe; // High on every host access to the watchdog bank.
	logic proc_reset; // Watchdog reset towards the processor.
	modport dev
	(
		input sclk, mosi, sel_n, watchdog_kick_strobe,
		output miso, tx_space_ready, config_change_irq, nmi, proc_reset
	);
	modport host
	(
		output sclk, mosi, sel_n, watchdog_kick_strobe,
		input miso, tx_space_ready, config_change_irq, nmi, proc_reset
	);
endinterface

/* File: hdl/csr_dev_end.sv */
/*
 Device end: control-register bank reached over the serial register port,
 identification string, loopback and rate controls, presence vector,
 side-band lines and the external watchdog.
 Assumes link inputs are synchronous to mclk_i and the host keeps SCK slow
 enough (half period of several cycles) for edge detection by sampling.
*/
// Overview of operation
// - Registers reached only over the select-5 serial port.
// - Each access: twelve address bits, one byte.
// - Address and data frames join into one access.
// - Register 000 bit 0: active-low soft reset.
// - Watchdog also resets logic on revised boards.
// - Register 000 reads return the identification string.
// - Reset clears pointer; each read advances it.
// - Loopback mode returns transmit traffic, blocks modules.
// - Register 001 bit 1 selects slow process mode.
// - Register 001 bit 7 reports card presence; here on revised boards only, zero otherwise.
// - Registers 002-003 give per-slot fast/slow rate.
// - Vector bit 0 is slot 1, ascending.
// - Registers 004-005 read slot occupancy.
// - Bits above the last fitted slot unused.
// - Ready line means room for 128 words.
// - Interrupt raised when installed modules change.
// - Rising edge on NMI before supply loss.
// - Host access restarts watchdog; 9 s timeout resets.
// - Write-only reads undefined; read-only writes ignored.
// - Software writes zero to reserved fields.
// - Host never touches addresses 010 through FFF.
`timescale 1ns/1ns
module csr_dev_end
#(
	parameter int unsigned WDOG_CYC = csr_pkg::WDOG_CYC_DEF
)
(
	input wire logic mclk_i,
	input wire logic rst_i,
	csr_link_if.dev link,
	input wire logic board_rev_nz_i,
	input wire logic [15:0] presence_i,
	input wire logic card_detect_i,
	input wire logic pwr_fail_i,
	input wire logic tx_space_i,
	input wire logic host_tx_valid_i,
	input wire logic [31:0] host_tx_data_i,
	input wire logic mod_rx_valid_i,
	input wire logic [31:0] mod_rx_data_i,
	output logic par_rx_valid_o,
	output logic [31:0] par_rx_data_o,
	output logic mod_tx_valid_o,
	output logic [31:0] mod_tx_data_o,
	output logic [15:0] slot_fast_o,
	output logic slow_mode_o,
	output logic logic_rst_o
);
	import csr_pkg::*;

	logic sclk_q; // Previous serial clock sample.
	logic sel_n_q; // Previous select sample.
	logic [15:0] shin_q; // Incoming shift register.
	logic [7:0] shout_q; // Outgoing shift register, bit 7 on the wire.
	logic [BITCNT_W-1:0] cnt_q; // Rising edges seen in the current frame.
	logic have_addr_q; // An address frame is waiting for its data frame.
	logic rd_q; // Pending access is a read.
	logic [11:0] addr_q; // Pending access address.
	logic [7:0] wdata_q; // Byte of a completed write.
	logic wr_stb_q; // One-cycle pulse: a write completed.
	logic rd_stb_q; // One-cycle pulse: a read completed.
	logic soft_q; // Soft reset bit, 0 holds the logic in reset.
	logic [ID_PTR_W-1:0] id_ptr_q; // Identification string read pointer.
	logic loop_q; // Loopback test mode.
	logic slow_q; // Slow process mode.
	logic [15:0] fast_q; // Per-slot rate vector.
	logic [15:0] pres_m_q; // Presence synchroniser first stage.
	logic [15:0] pres_s_q; // Presence synchroniser second stage.
	logic [15:0] pres_q; // Presence, one cycle older, for change detection.
	logic [1:0] pf_q; // Supply-fail synchroniser.
	logic nmi_q; // NMI line.
	logic [7:0] irq_cnt_q; // Interrupt pulse stretcher.
	logic irq_q; // Interrupt line.
	logic [31:0] wd_cnt_q; // Watchdog counter.
	logic wd_rst_q; // Watchdog reset active.
	logic hard_rst; // Button or watchdog reset.
	logic lrst; // Reset of everything behind the soft reset bit.
	logic rise;
	logic fall;
	logic start;
	logic stop;
	logic [7:0] rd_byte; // Byte presented for a read.

	// Returns one byte of the identification string; the tail reads as zero.
	function automatic logic [7:0] id_byte(input logic [ID_PTR_W-1:0] idx);
		logic [7:0] b;
		b = BYTE_ZERO;
		if (int'(idx) < ID_TEXT_LEN)
		begin
			b = ID_TEXT[8 * (ID_TEXT_LEN - 1 - int'(idx)) +: 8];
		end
		return b;
	endfunction

	// The watchdog reset reaches the logic only on revised boards.
	// watchdog logic reset
	assign hard_rst = rst_i | (wd_rst_q & board_rev_nz_i);
	assign lrst = hard_rst | ~soft_q;
	assign logic_rst_o = lrst;

	// Edge and frame detection on the sampled port lines.
	// select framing
	assign rise = link.sclk & ~sclk_q & ~link.sel_n;
	assign fall = ~link.sclk & sclk_q & ~link.sel_n;
	assign start = ~link.sel_n & sel_n_q;
	assign stop = link.sel_n & ~sel_n_q;
	assign link.miso = shout_q[7];

	// Line history for edge detection.
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			sclk_q <= 1'b0;
			sel_n_q <= 1'b1;
		end
		else
		begin
			sclk_q <= link.sclk;
			sel_n_q <= link.sel_n;
		end
	end

	// Serial slave. Kept on the hard reset so software can always set the
	// soft reset bit; a soft reset must not lock out the port itself.
	always_ff @(posedge mclk_i)
	begin
		if (hard_rst)
		begin
			shin_q <= VEC_ZERO;
			shout_q <= BYTE_ZERO;
			cnt_q <= '0;
			have_addr_q <= 1'b0;
			rd_q <= 1'b0;
			addr_q <= REG_CTRL_ID;
			wdata_q <= BYTE_ZERO;
			wr_stb_q <= 1'b0;
			rd_stb_q <= 1'b0;
		end
		else
		begin
			wr_stb_q <= 1'b0;
			rd_stb_q <= 1'b0;
			if (start)
			begin
				cnt_q <= '0;
				// The read byte must sit on the wire before the first rising edge.
				if (have_addr_q && rd_q)
				begin
					shout_q <= rd_byte;
				end
			end
			if (rise)
			begin
				shin_q <= {shin_q[14:0], link.mosi};
				// Saturate so an overlong frame cannot wrap into a valid length.
				if (cnt_q != '1)
				begin
					cnt_q <= cnt_q + 1'b1;
				end
			end
			if (fall)
			begin
				shout_q <= {shout_q[6:0], 1'b0};
			end
			if (stop)
			begin
				if (!have_addr_q && cnt_q == BITCNT_W'(ADDR_FRAME_BITS))
				begin
					have_addr_q <= 1'b1;
					rd_q <= shin_q[RW_BIT];
					addr_q <= shin_q[ADDR_W-1:0];
				end
				else if (have_addr_q && cnt_q == BITCNT_W'(DATA_FRAME_BITS))
				begin
					have_addr_q <= 1'b0;
					wr_stb_q <= ~rd_q;
					rd_stb_q <= rd_q;
					wdata_q <= shin_q[DATA_W-1:0];
				end
				else
				begin
					// A frame of the wrong length drops the pending access.
					have_addr_q <= 1'b0;
				end
			end
		end
	end

	// Read multiplexer; write-only locations read as zero.
	always_comb
	begin
		rd_byte = BYTE_ZERO;
		case (addr_q)
			REG_CTRL_ID: rd_byte = id_byte(id_ptr_q);
			REG_TEST: rd_byte[CARD_BIT] = card_detect_i & board_rev_nz_i;
			REG_OCC_LO: rd_byte = pres_s_q[7:0];
			REG_OCC_HI: rd_byte = pres_s_q[15:8];
			default: rd_byte = BYTE_ZERO;
		endcase
	end

	// Soft reset bit, reset only by the button or the watchdog.
	always_ff @(posedge mclk_i)
	begin
		if (hard_rst)
		begin
			soft_q <= SOFT_RST_RESET;
		end
		else if (wr_stb_q && addr_q == REG_CTRL_ID)
		begin
			soft_q <= wdata_q[SOFT_RST_BIT];
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (lrst)
		begin
			id_ptr_q <= '0;
		end
		else if (rd_stb_q && addr_q == REG_CTRL_ID)
		begin
			id_ptr_q <= id_ptr_q + 1'b1;
		end
	end

	// Control registers; writes to read-only offsets fall through unchanged.
	always_ff @(posedge mclk_i)
	begin
		if (lrst)
		begin
			loop_q <= 1'b0;
			slow_q <= 1'b0;
			fast_q <= VEC_ZERO;
		end
		else if (wr_stb_q)
		begin
			case (addr_q)
				REG_TEST:
				begin
					loop_q <= wdata_q[LOOPBACK_BIT];
					slow_q <= wdata_q[SLOW_BIT];
				end
				REG_RATE_LO: fast_q[7:0] <= wdata_q;
				REG_RATE_HI: fast_q[15:8] <= wdata_q;
				default: fast_q <= fast_q;
			endcase
		end
	end
	assign slot_fast_o = fast_q;
	assign slow_mode_o = slow_q;

	// loopback path, registered so data outputs come from flops.
	always_ff @(posedge mclk_i)
	begin
		if (lrst)
		begin
			par_rx_valid_o <= 1'b0;
			par_rx_data_o <= '0;
			mod_tx_valid_o <= 1'b0;
			mod_tx_data_o <= '0;
		end
		else
		begin
			par_rx_valid_o <= loop_q ? host_tx_valid_i : mod_rx_valid_i;
			par_rx_data_o <= loop_q ? host_tx_data_i : mod_rx_data_i;
			mod_tx_valid_o <= host_tx_valid_i & ~loop_q;
			mod_tx_data_o <= host_tx_data_i;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (lrst)
		begin
			pres_m_q <= VEC_ZERO;
			pres_s_q <= VEC_ZERO;
			pres_q <= VEC_ZERO;
		end
		else
		begin
			pres_m_q <= presence_i;
			pres_s_q <= pres_m_q;
			pres_q <= pres_s_q;
		end
	end

	// change interrupt, stretched so the processor cannot miss it.
	always_ff @(posedge mclk_i)
	begin
		if (lrst)
		begin
			irq_cnt_q <= BYTE_ZERO;
			irq_q <= 1'b0;
		end
		else if (pres_s_q != pres_q)
		begin
			irq_cnt_q <= 8'(IRQ_HOLD_CYC - 1);
			irq_q <= 1'b1;
		end
		else if (irq_cnt_q != BYTE_ZERO)
		begin
			irq_cnt_q <= irq_cnt_q - 1'b1;
		end
		else
		begin
			irq_q <= 1'b0;
		end
	end
	assign link.config_change_irq = irq_q;

	// supply-fail NMI, on the hard reset so a soft reset cannot mask it.
	always_ff @(posedge mclk_i)
	begin
		if (hard_rst)
		begin
			pf_q <= 2'b00;
			nmi_q <= 1'b0;
		end
		else
		begin
			pf_q <= {pf_q[0], pwr_fail_i};
			nmi_q <= pf_q[1];
		end
	end
	assign link.nmi = nmi_q;

	assign link.tx_space_ready = tx_space_i & ~lrst;

	// watchdog: a kick restarts the count; timeout holds reset briefly.
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			wd_cnt_q <= '0;
			wd_rst_q <= 1'b0;
		end
		else if (wd_cnt_q == WDOG_CYC + RST_HOLD_CYC - 1)
		begin
			wd_cnt_q <= '0;
			wd_rst_q <= 1'b0;
		end
		else if (link.watchdog_kick_strobe && !wd_rst_q)
		begin
			wd_cnt_q <= '0;
		end
		else
		begin
			wd_cnt_q <= wd_cnt_q + 1'b1;
			wd_rst_q <= (wd_cnt_q + 1'b1) >= WDOG_CYC;
		end
	end
	assign link.proc_reset = wd_rst_q;
	// Slot count is not known here: every bit above the fitted slots is
	// simply stored in the rate vector or passed through as occupancy, which the host ignores.
	// unused bits
endmodule

/* File: hdl/csr_host_end.sv */
/*
 Host end: the processor side of the register port. Turns one command into
 an address frame and a data frame and passes the side-band lines through.
 Assumes the device end samples the link on the same mclk_i.
*/
`timescale 1ns/1ns
module csr_host_end
(
	input wire logic mclk_i,
	input wire logic rst_i,
	csr_link_if.host link,
	input wire logic cmd_valid_i,
	input wire logic cmd_write_i,
	input wire logic [11:0] cmd_addr_i,
	input wire logic [7:0] cmd_wdata_i,
	input wire logic kick_i,
	output logic cmd_ready_o,
	output logic rsp_valid_o,
	output logic [7:0] rsp_rdata_o,
	output logic tx_ready_o,
	output logic irq_o,
	output logic nmi_o,
	output logic proc_reset_o
);
	import csr_pkg::*;

	csr_host_state_t state_q; // Sequencer state.
	logic [DIV_W-1:0] div_q; // Half-period divider.
	logic tick; // One-cycle enable at each half period.
	logic data_ph_q; // 0 during the address frame, 1 during the data frame.
	logic [BITCNT_W-1:0] bits_q; // Bits left in the frame.
	logic [15:0] sh_q; // Outgoing shift register, bit 15 on the wire.
	logic [7:0] rx_q; // Incoming byte.
	logic [7:0] wdata_q; // Held write byte.
	logic sck_q;
	logic sel_n_q;

	assign tick = (div_q == DIV_W'(SCK_HALF_CYC - 1));
	assign cmd_ready_o = (state_q == CSR_H_IDLE);
	assign link.sclk = sck_q;
	assign link.mosi = sh_q[15];
	assign link.sel_n = sel_n_q;
	// each host kick marks a watchdog bank access
	assign link.watchdog_kick_strobe = kick_i;
	// host honours the ready line upstream of this port
	assign tx_ready_o = link.tx_space_ready;
	assign irq_o = link.config_change_irq;
	assign nmi_o = link.nmi;
	assign proc_reset_o = link.proc_reset;

	// Divider, free while a command runs.
	always_ff @(posedge mclk_i)
	begin
		if (rst_i || state_q == CSR_H_IDLE || tick)
		begin
			div_q <= '0;
		end
		else
		begin
			div_q <= div_q + 1'b1;
		end
	end

	// Frame sequencer.
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			state_q <= CSR_H_IDLE;
			data_ph_q <= 1'b0;
			bits_q <= '0;
			sh_q <= VEC_ZERO;
			rx_q <= BYTE_ZERO;
			wdata_q <= BYTE_ZERO;
			sck_q <= 1'b0;
			sel_n_q <= 1'b1;
			rsp_valid_o <= 1'b0;
			rsp_rdata_o <= BYTE_ZERO;
		end
		else
		begin
			rsp_valid_o <= 1'b0;
			case (state_q)
				CSR_H_IDLE:
				begin
					if (cmd_valid_i)
					begin
						// address frame with read flag on top
						sh_q <= {~cmd_write_i, 3'b000, cmd_addr_i};
						wdata_q <= cmd_write_i ? cmd_wdata_i : BYTE_ZERO;
						bits_q <= BITCNT_W'(ADDR_FRAME_BITS);
						data_ph_q <= 1'b0;
						sel_n_q <= 1'b0;
						state_q <= CSR_H_SHIFT;
					end
				end
				CSR_H_SHIFT:
				begin
					if (tick && !sck_q)
					begin
						sck_q <= 1'b1;
						rx_q <= {rx_q[6:0], link.miso};
						bits_q <= bits_q - 1'b1;
					end
					else if (tick)
					begin
						sck_q <= 1'b0;
						if (bits_q == '0)
						begin
							sel_n_q <= 1'b1;
							state_q <= CSR_H_GAP;
						end
						else
						begin
							sh_q <= {sh_q[14:0], 1'b0};
						end
					end
				end
				CSR_H_GAP:
				begin
					// separate data frame after the address frame
					if (tick && !data_ph_q)
					begin
						sh_q <= {wdata_q, BYTE_ZERO};
						bits_q <= BITCNT_W'(DATA_FRAME_BITS);
						data_ph_q <= 1'b1;
						sel_n_q <= 1'b0;
						state_q <= CSR_H_SHIFT;
					end
					else if (tick)
					begin
						state_q <= CSR_H_DONE;
					end
				end
				CSR_H_DONE:
				begin
					rsp_valid_o <= 1'b1;
					rsp_rdata_o <= rx_q;
					state_q <= CSR_H_IDLE;
				end
				default: state_q <= CSR_H_IDLE;
			endcase
		end
	end
endmodule

/* File: bench/csr_link_checker.sv */
/*
 Wire checker for the register link between the host end and the device end.
 Assumes one clock and a synchronous active-high reset shared by both ends.
*/
`timescale 1ns/1ns
module csr_link_checker
#(
	parameter int unsigned WDOG_CYC = csr_pkg::WDOG_CYC_DEF
)
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic miso,
	input wire logic sel_n,
	input wire logic tx_space_ready,
	input wire logic config_change_irq,
	input wire logic nmi,
	input wire logic watchdog_kick_strobe,
	input wire logic proc_reset
);
	import csr_pkg::*;
	logic sclk_q; // Serial clock seen one cycle earlier.
	logic [4:0] bits_q; // Clock rises counted in the open frame.
	logic last16_q; // The frame before was an address frame.
	logic [7:0] irq_run_q; // Cycles the change interrupt has stood.
	logic [7:0] rst_run_q; // Cycles the processor reset has stood.
	int unsigned idle_q; // Cycles since the last kick or reset hold.
	default clocking dc @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);
	// Counts clock rises in a frame; the count clears once select goes high.
	always_ff @(posedge mclk_i)
	begin
		sclk_q <= sclk;
		if (rst_i || sel_n)
		begin
			bits_q <= 5'h00;
		end
		else if (sclk && !sclk_q)
		begin
			bits_q <= bits_q + 5'h01;
		end
	end
	// Keeps the length class of the last finished frame, so order can be judged.
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			last16_q <= 1'b0;
		end
		else if (sel_n && bits_q != 5'h00)
		begin
			last16_q <= (bits_q == 5'h10);
		end
	end
	// Pulse widths and the idle span; the hold restarts the span as the ends do.
	always_ff @(posedge mclk_i)
	begin
		irq_run_q <= (rst_i || !config_change_irq) ? 8'h00 : irq_run_q + 8'h01;
		rst_run_q <= (rst_i || !proc_reset) ? 8'h00 : rst_run_q + 8'h01;
		idle_q <= (rst_i || watchdog_kick_strobe || proc_reset) ? 0 : idle_q + 1;
	end
	// The high phase of one bit lasts four cycles.
	sequence s_high_phase;
		sclk [*4] ##1 !sclk;
	endsequence
	// A line stays put for the rest of the high phase.
	sequence s_steady(sig);
		$stable(sig) [*3];
	endsequence
	a_sclk_idle_low: assert property (sel_n |-> !sclk)
		else $error("Serial clock high while the port is deselected.");
	a_sclk_high_len: assert property ($rose(sclk) |-> s_high_phase)
		else $error("Serial clock high phase has the wrong length.");
	a_mosi_steady: assert property ($rose(sclk) |=> s_steady(mosi))
		else $error("Host data moved while the clock was high.");
	a_miso_steady: assert property ($rose(sclk) |=> s_steady(miso))
		else $error("Device data moved while the clock was high.");
	a_frame_len: assert property ($rose(sel_n) |-> bits_q == 5'h10 || bits_q == 5'h08)
		else $error("Frame is neither sixteen nor eight bits long.");
	a_frame_order: assert property ($rose(sel_n) && bits_q == 5'h08 |-> last16_q)
		else $error("Data frame not preceded by an address frame.");
	a_irq_hold_len: assert property ($fell(config_change_irq)
		|-> irq_run_q == IRQ_HOLD_CYC)
		else $error("Change interrupt pulse has the wrong width.");
	a_rst_hold_len: assert property ($fell(proc_reset) |-> rst_run_q == RST_HOLD_CYC)
		else $error("Processor reset hold has the wrong width.");
	a_wdog_timing: assert property ($rose(proc_reset) |-> idle_q + 4 >= WDOG_CYC
		&& idle_q <= WDOG_CYC + 4)
		else $error("Watchdog fired at the wrong idle span.");
endmodule

/* File: bench/crate_fpga_spi_control_registers_tb_top.sv */
/*
 Self-checking bench: host end and device end joined by the link interface,
 with the wire checker beside it. Assumes the package and design are compiled first.
*/
`timescale 1ns/1ns
module crate_fpga_spi_control_registers_tb_top;
	import csr_pkg::*;
	localparam int unsigned WD = 600; // Short watchdog span keeps the run brief.
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic rev = 1'b0; // Board revision is zero until the card presence test.
	logic [15:0] pres = 16'h0000; // Slot occupancy seen by the device.
	logic card = 1'b0;
	logic pfail = 1'b0;
	logic txsp = 1'b1;
	logic hv = 1'b0;
	logic [31:0] hdat = 32'h00000000;
	logic mv = 1'b0;
	logic [31:0] mdat = 32'h00000000;
	logic cv = 1'b0;
	logic cw = 1'b0;
	logic [11:0] ca = 12'h000;
	logic [7:0] cd = 8'h00;
	logic kick = 1'b0;
	logic pv, mtv, slow, lrst, crdy, rv, txr, irq, nmi, prst;
	logic [31:0] pdat, mtd;
	logic [15:0] fast;
	logic [7:0] rdat;
	logic [32:0] note; // Oldest expected response taken by the monitor.
	logic [31:0] v;
	logic [31:0] seed = 32'h0001384B;
	logic [32:0] rq[$]; // Expected register responses, flag on top.
	logic [31:0] pq[$]; // Expected parallel receive words.
	int num_errors = 0;
	int n_compared = 0;
	csr_link_if u_csr_link_if();
	csr_dev_end #(.WDOG_CYC(WD)) u_csr_dev_end (.mclk_i(mclk_i), .rst_i(rst_i),
		.link(u_csr_link_if.dev), .board_rev_nz_i(rev), .presence_i(pres),
		.card_detect_i(card), .pwr_fail_i(pfail), .tx_space_i(txsp),
		.host_tx_valid_i(hv), .host_tx_data_i(hdat), .mod_rx_valid_i(mv),
		.mod_rx_data_i(mdat), .par_rx_valid_o(pv), .par_rx_data_o(pdat),
		.mod_tx_valid_o(mtv), .mod_tx_data_o(mtd), .slot_fast_o(fast),
		.slow_mode_o(slow), .logic_rst_o(lrst));
	csr_host_end u_csr_host_end (.mclk_i(mclk_i), .rst_i(rst_i), .link(u_csr_link_if.host),
		.cmd_valid_i(cv), .cmd_write_i(cw), .cmd_addr_i(ca), .cmd_wdata_i(cd),
		.kick_i(kick), .cmd_ready_o(crdy), .rsp_valid_o(rv), .rsp_rdata_o(rdat),
		.tx_ready_o(txr), .irq_o(irq), .nmi_o(nmi), .proc_reset_o(prst));
	csr_link_checker #(.WDOG_CYC(WD)) u_csr_link_checker (.mclk_i(mclk_i), .rst_i(rst_i),
		.sclk(u_csr_link_if.sclk), .mosi(u_csr_link_if.mosi), .miso(u_csr_link_if.miso),
		.sel_n(u_csr_link_if.sel_n), .tx_space_ready(u_csr_link_if.tx_space_ready),
		.config_change_irq(u_csr_link_if.config_change_irq), .nmi(u_csr_link_if.nmi),
		.watchdog_kick_strobe(u_csr_link_if.watchdog_kick_strobe),
		.proc_reset(u_csr_link_if.proc_reset));
	// Free-running controller clock.
	initial
	begin
		forever #25 mclk_i = ~mclk_i;
	end
	// Xorshift source; the fixed start keeps runs repeatable.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Compares a value and reports a mismatch at once.
	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Compares a single flag.
	task automatic cmp_flag(input logic got, input logic exp);
		cmp_reg({31'h0, got}, {31'h0, exp});
	endtask
	// One register access; reads note the byte they should return.
	task automatic access(input logic wr, input logic [11:0] a, input logic [7:0] d,
		input logic [7:0] e);
		rq.push_back({~wr, 24'h000000, e});
		@(posedge mclk_i);
		cv <= 1'b1;
		cw <= wr;
		ca <= a;
		cd <= d;
		kick <= 1'b1;
		@(posedge mclk_i);
		cv <= 1'b0;
		kick <= 1'b0;
		repeat (400) if (rv !== 1'b1) @(negedge mclk_i);
		cmp_flag(rv, 1'b1);
		cmp_flag(crdy, 1'b1);
	endtask
	// Sends one word each way; the parallel port should carry the chosen one.
	task automatic xfer(input logic loop);
		logic [31:0] h;
		logic [31:0] m;
		h = rnd();
		m = rnd();
		pq.push_back(loop ? h : m);
		@(posedge mclk_i);
		hv <= 1'b1;
		hdat <= h;
		mv <= 1'b1;
		mdat <= m;
		@(posedge mclk_i);
		hv <= 1'b0;
		mv <= 1'b0;
		@(negedge mclk_i);
		cmp_flag(mtv, ~loop);
		if (!loop) cmp_reg(mtd, h);
	endtask
	// Takes the oldest note whenever the design answers.
	always @(negedge mclk_i)
	begin
		if (rv === 1'b1)
		begin
			note = rq.pop_front();
			if (note[32]) cmp_reg({24'h0, rdat}, {24'h0, note[7:0]});
		end
		if (pv === 1'b1) cmp_reg(pdat, pq.size() ? pq.pop_front() : ~pdat);
	end
	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up();
		$display("compared=%0d errors=%0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
		begin
			$display("SIMULATION PASSED");
		end
		else
		begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Cuts a hang short well beyond the expected run length.
	initial
	begin
		repeat (30000) @(posedge mclk_i);
		num_errors++;
		wrap_up();
	end
	// Main sequence.
	initial
	begin
		repeat (5) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(negedge mclk_i);
		cmp_flag(u_csr_link_if.sel_n, 1'b1);
		cmp_flag(lrst, 1'b1);
		cmp_flag(txr, 1'b0);
		access(1'b1, REG_RATE_LO, 8'h5A, 8'h00);
		cmp_reg({16'h0, fast}, 32'h0);
		access(1'b1, REG_CTRL_ID, 8'h01, 8'h00);
		cmp_flag(lrst, 1'b0);
		cmp_flag(txr, 1'b1);
		for (int i = 0; i < 18; i++)
		begin
			access(1'b0, REG_CTRL_ID, 8'h00, i < 16 ? ID_TEXT[127 - 8 * i -: 8] : 8'h00);
		end
		for (int r = 0; r < 2; r++)
		begin
			@(posedge mclk_i);
			rev <= r[0];
			card <= 1'b1;
			access(1'b0, REG_TEST, 8'h00, {r[0], 7'h00});
		end
		for (int k = 0; k < 3; k++)
		begin
			v = k ? rnd() : 32'h00008001;
			access(1'b1, REG_RATE_LO, v[7:0], 8'h00);
			access(1'b1, REG_RATE_HI, v[15:8], 8'h00);
			cmp_reg({16'h0, fast}, {16'h0, v[15:0]});
		end
		access(1'b0, REG_RATE_HI, 8'h00, 8'h00);
		v = rnd() | 32'h00000001;
		@(posedge mclk_i);
		pres <= v[15:0];
		repeat (10) if (irq !== 1'b1) @(negedge mclk_i);
		cmp_flag(irq, 1'b1);
		access(1'b1, REG_OCC_LO, ~v[7:0], 8'h00);
		access(1'b0, REG_OCC_LO, 8'h00, v[7:0]);
		access(1'b0, REG_OCC_HI, 8'h00, v[15:8]);
		access(1'b0, REG_RATE_LO, 8'h00, 8'h00);
		access(1'b1, REG_TEST, 8'h01, 8'h00);
		cmp_flag(slow, 1'b0);
		xfer(1'b1);
		access(1'b1, REG_TEST, 8'h02, 8'h00);
		cmp_flag(slow, 1'b1);
		xfer(1'b0);
		cmp_flag(nmi, 1'b0);
		@(posedge mclk_i);
		pfail <= 1'b1;
		txsp <= 1'b0;
		kick <= 1'b1;
		@(posedge mclk_i);
		kick <= 1'b0;
		repeat (8) if (nmi !== 1'b1) @(negedge mclk_i);
		cmp_flag(nmi, 1'b1);
		cmp_flag(txr, 1'b0);
		repeat (WD - 50) @(posedge mclk_i);
		kick <= 1'b1;
		@(posedge mclk_i);
		kick <= 1'b0;
		repeat (WD - 50) @(negedge mclk_i);
		cmp_flag(prst, 1'b0);
		repeat (100) if (prst !== 1'b1) @(negedge mclk_i);
		cmp_flag(prst, 1'b1);
		cmp_flag(lrst, 1'b1);
		repeat (RST_HOLD_CYC + 2) @(negedge mclk_i);
		cmp_reg({16'h0, fast}, 32'h0);
		access(1'b1, REG_CTRL_ID, 8'h01, 8'h00);
		access(1'b0, REG_CTRL_ID, 8'h00, ID_TEXT[127 -: 8]);
		wrap_up();
	end
endmodule
